// ==== design/sar_adc_pkg.sv ====
package sar_adc_pkg;

    // register indices; the byte address is four times the index
    localparam logic [12:0] IDX_IRQ_MASK    = 13'h0008;
    localparam logic [12:0] IDX_IRQ_PENDING = 13'h0009;
    localparam logic [12:0] IDX_RESULT      = 13'h1FAA;
    localparam logic [12:0] IDX_COMMAND     = 13'h1FAC;
    localparam logic [12:0] IDX_TEST        = 13'h1FAE;
    localparam logic [12:0] IDX_TIMING      = 13'h1FAF;
    localparam logic [12:0] IDX_PIN_STATE   = 13'h1FDA;

    // field positions
    localparam int CMD_CHAN_LSB = 0;
    localparam int CMD_GO_BIT   = 3;
    localparam int CMD_MODE_LSB = 4;
    localparam int TEST_TE_BIT  = 0;
    localparam int TEST_TV_BIT  = 1;
    localparam int TEST_OFF_LSB = 2;
    localparam int TIME_CONV_LSB = 0;
    localparam int TIME_SAM_LSB = 5;
    localparam int RES_CHAN_LSB = 0;
    localparam int RES_BUSY_BIT = 3;
    localparam int RES_LSB_POS  = 6;
    localparam int IRQ_AD_BIT   = 1;

    // reset values
    localparam logic [7:0]  RST_COMMAND = 8'hC0;
    localparam logic [7:0]  RST_TEST    = 8'hC0;
    localparam logic [15:0] RST_RESULT  = 16'h7F80;
    localparam logic [7:0]  RST_TIMING  = 8'h00;
    localparam logic [7:0]  RST_MASK    = 8'h00;
    localparam logic [7:0]  RST_PENDING = 8'h00;

    // timing: one state time per pclk cycle
    localparam int CLK_PERIOD_PS    = 25000;
    localparam int START_LIMIT_PS   = 75000;
    localparam int SAMPLE_DELAY_CYC = START_LIMIT_PS / CLK_PERIOD_PS - 1;
    localparam int SAMPLE_UNIT_CYC  = 8;
    localparam int ZERO_CYC         = 1;

    // approximation register patterns
    localparam logic [9:0] SAR_HALF_SCALE = 10'h1FF;
    localparam logic [9:0] SAR_CLEAR      = 10'h000;

    typedef enum logic [1:0] {
        MODE_10BIT    = 2'b00,
        MODE_8BIT     = 2'b01,
        MODE_THRESH_HI = 2'b10,
        MODE_THRESH_LO = 2'b11
    } conversion_mode_select_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ARMED  = 3'b001,
        ST_DELAY  = 3'b010,
        ST_SAMPLE = 3'b011,
        ST_ZERO   = 3'b100,
        ST_TRIAL  = 3'b101,
        ST_THRESH = 3'b110
    } adc_state_t;

endpackage

// ==== design/sar_adc_sequencer.sv ====
// Function
// [RULE_01] convert selected input to 8 or 10 bits, store result, set pending flag
// [RULE_02] threshold mode watches input and sets pending flag on crossing reference
// [RULE_03] result high byte holds 8 MSBs; low byte holds LSBs, channel, busy
// [RULE_04] software writes threshold into result high byte before threshold detect
// [RULE_05] convert an input channel or a test voltage, with zero-offset adjustment
// [RULE_06] start from command write or from event processor event, per command
// [RULE_07] immediate start within three state times; event start follows the event
// [RULE_08] during sample delay clear approximation register and select the channel
// [RULE_09] after delay connect sample switch for programmed time, then open it
// [RULE_10] after sample window zero comparator, then begin the trials
// [RULE_11] approximation register is 10 bits; 8-bit mode uses coarse ladder only
// [RULE_12] first trial half scale; keep or set bit, clear next bit, repeat
// [RULE_13] exactly 10 or 8 trials, then result readable
// [RULE_14] full scale input produces an all-ones result
// [RULE_15] 8-bit conversion finishes sooner than 10-bit conversion
// [RULE_16] interrupt reaches processor only while mask bit is set
// [RULE_17] pending bit reads one while a converter request is outstanding
// [RULE_18] pin state register is clocked only on software reads
// [RULE_19] software should not read pin state while converting
// [RULE_20] analog inputs come from port zero pins 7..4 with no configuration
// [RULE_21] command register holds channel, trigger choice and mode
// [RULE_22] timing register sets sample window and per-bit conversion time
// [RULE_23] mode codes 00..11 select 10-bit, 8-bit, detect high, detect low
// [RULE_24] command write arms; trigger bit one starts now, zero waits for event
// [RULE_25] any command write cancels threshold detection and runs the new command
// [RULE_26] test enable selects test conversion; test voltage picks reference or ground
// [RULE_27] busy from accepted start until final trial stored, then idle
// [RULE_28] sample window and bit trials timed by counters loaded from timing fields
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module sar_adc_sequencer
    import sar_adc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        epa_event,
    input  wire logic        comp_high,
    input  wire logic [7:0]  port_zero_pins,
    output logic      [9:0]  approximation_register,
    output logic      [1:0]  mux_channel,
    output logic             test_enable_bit,
    output logic             test_voltage_select,
    output logic      [1:0]  zero_offset_adjust,
    output logic             sample_switch,
    output logic             comparator_zero,
    output logic             ad_irq
);

    typedef struct packed {
        // sequencing
        adc_state_t  state;
        logic [7:0]  cnt;
        logic [3:0]  bit_idx;
        logic [9:0]  sar;

        // software registers
        logic [7:0]  command;
        logic [7:0]  test;
        logic [7:0]  timing;
        logic [15:0] result;
        logic [7:0]  mask;
        logic [7:0]  pending;
        logic [7:0]  pin_state;

        // threshold watch
        logic        thr_prev;
        logic        thr_valid;

        // bus answer
        logic [31:0] rdata;
        logic        ready;
        logic        err;

        // analog strobes and request
        logic        sample;
        logic        zero;
        logic        irq;
    } regs_t;

    regs_t st;
    regs_t next_st;

    function automatic logic hit(input logic [15:0] a, input logic [12:0] idx);
        return a == {1'b0, idx, 2'b00};
    endfunction

    function automatic logic [7:0] sample_cycles(input logic [7:0] t);
        logic [2:0] sam;
        sam = t[TIME_SAM_LSB +: 3];
        // a zero field counts as one unit, never an empty window
        if (sam == 3'h0) begin
            sam = 3'h1;
        end
        return 8'(sam * SAMPLE_UNIT_CYC);
    endfunction

    function automatic logic [7:0] trial_cycles(input logic [7:0] t);
        // each trial lasts the field plus one cycle
        return {3'h0, t[TIME_CONV_LSB +: 5]} + 8'h01;
    endfunction

    logic                    access;
    logic                    wr_done;
    logic                    mapped;
    // register decode for the read path; all but sel_cmd and sel_pin also serve the write path
    logic                    sel_mask;
    logic                    sel_pend;
    logic                    sel_res;
    logic                    sel_cmd;
    logic                    sel_test;
    logic                    sel_time;
    logic                    sel_pin;
    logic                    busy;
    logic                    ad_event;
    logic                    crossed;
    conversion_mode_select_t mode;

    always_comb begin
        next_st  = st;
        access   = psel && penable;
        wr_done  = access && pwrite && st.ready;
        mode     = conversion_mode_select_t'(st.command[CMD_MODE_LSB +: 2]);
        busy     = (st.state != ST_IDLE) && (st.state != ST_ARMED);
        ad_event = 1'b0;
        crossed  = 1'b0;

        sel_mask = hit(paddr, IDX_IRQ_MASK);
        sel_pend = hit(paddr, IDX_IRQ_PENDING);
        sel_res  = hit(paddr, IDX_RESULT);
        sel_cmd  = hit(paddr, IDX_COMMAND);
        sel_test = hit(paddr, IDX_TEST);
        sel_time = hit(paddr, IDX_TIMING);
        sel_pin  = hit(paddr, IDX_PIN_STATE);
        mapped   = sel_mask || sel_pend ||
                   sel_res ||
                   sel_cmd ||
                   sel_test ||
                   sel_time ||
                   sel_pin;

        // one wait state so that read data leaves a flip-flop
        next_st.ready = 1'b0;
        next_st.err   = 1'b0;
        if (access && !st.ready) begin
            next_st.ready = 1'b1;
            next_st.err   = !mapped;
            next_st.rdata = 32'h0000_0000;
            if (!pwrite) begin
                if (sel_mask) begin
                    next_st.rdata[7:0] = st.mask;
                end

                if (sel_pend) begin
                    next_st.rdata[7:0] = st.pending; // [RULE_17]
                end

                if (sel_res) begin
                    next_st.rdata[15:0] = st.result; // [RULE_03]
                    next_st.rdata[RES_BUSY_BIT] = busy; // [RULE_27]
                end

                if (sel_cmd) begin
                    next_st.rdata[7:0] = st.command;
                end

                if (sel_test) begin
                    next_st.rdata[7:0] = st.test;
                end

                if (sel_time) begin
                    next_st.rdata[7:0] = st.timing;
                end

                if (sel_pin) begin
                    // the pin register loads only here, keeping read noise off idle time
                    next_st.pin_state  = port_zero_pins; // [RULE_18]
                    next_st.rdata[7:0] = port_zero_pins; // [RULE_18]
                end
            end
        end

        // register writes take effect at the completing edge
        // a write to an unmapped word changes nothing
        if (wr_done) begin
            if (sel_mask) begin
                next_st.mask = pwdata[7:0];
            end

            if (sel_pend) begin
                next_st.pending = pwdata[7:0];
            end

            if (sel_res) begin
                next_st.result = pwdata[15:0]; // [RULE_04]
            end

            if (sel_test) begin
                next_st.test = pwdata[7:0]; // [RULE_26]
            end

            if (sel_time) begin
                next_st.timing = pwdata[7:0]; // [RULE_22]
            end
        end

        next_st.sample = 1'b0;
        next_st.zero   = 1'b0;

        case (st.state)
            ST_IDLE: begin
                // parked; only a command write leaves
            end

            ST_ARMED: begin
                // a pulse outside the armed state is ignored
                if (epa_event) begin
                    next_st.state = ST_DELAY; // [RULE_07]
                    next_st.cnt   = 8'(SAMPLE_DELAY_CYC);
                end
            end

            ST_DELAY: begin
                next_st.sar = SAR_CLEAR; // [RULE_08]
                if (st.cnt <= 8'h01) begin
                    next_st.state  = ST_SAMPLE;
                    next_st.cnt    = sample_cycles(st.timing); // [RULE_28]
                    next_st.sample = 1'b1; // [RULE_09]
                end else begin
                    next_st.cnt = st.cnt - 8'h01;
                end
            end

            ST_SAMPLE: begin
                if (st.cnt <= 8'h01) begin
                    // switch opens before any trial so the held charge stays put
                    if (mode == MODE_THRESH_HI || mode == MODE_THRESH_LO) begin
                        next_st.state     = ST_THRESH;
                        next_st.sar       = {st.result[15:8], 2'b00}; // [RULE_02]
                        next_st.sample    = 1'b1;
                        next_st.thr_valid = 1'b0;
                    end else begin
                        next_st.state = ST_ZERO; // [RULE_10]
                        next_st.zero  = 1'b1; // [RULE_10]
                        next_st.cnt   = 8'(ZERO_CYC);
                    end
                end else begin
                    next_st.sample = 1'b1; // [RULE_09]
                    next_st.cnt    = st.cnt - 8'h01; // [RULE_28]
                end
            end

            ST_ZERO: begin
                if (st.cnt <= 8'h01) begin
                    next_st.state   = ST_TRIAL;
                    next_st.sar     = SAR_HALF_SCALE; // [RULE_12]
                    next_st.bit_idx = 4'h9;
                    next_st.cnt     = trial_cycles(st.timing); // [RULE_28]
                end else begin
                    next_st.zero = 1'b1;
                    next_st.cnt  = st.cnt - 8'h01;
                end
            end

            ST_TRIAL: begin
                if (st.cnt <= 8'h01) begin
                    if (comp_high) begin
                        next_st.sar[st.bit_idx] = 1'b1; // [RULE_12]
                    end
                    // 8-bit mode stops after bit 2: two trials fewer
                    if ((mode == MODE_8BIT && st.bit_idx == 4'h2) ||
                        st.bit_idx == 4'h0) begin // [RULE_13] [RULE_15] [RULE_11]
                        next_st.state = ST_IDLE; // [RULE_27]
                        next_st.result[15:8] = next_st.sar[9:2]; // [RULE_01] [RULE_14]
                        next_st.result[RES_LSB_POS +: 2] = next_st.sar[1:0]; // [RULE_03]
                        // bits 5:4 are unused and read zero after a conversion
                        next_st.result[5:4] = 2'b00;
                        next_st.result[RES_BUSY_BIT] = 1'b0;
                        next_st.result[RES_CHAN_LSB +: 3] = st.command[CMD_CHAN_LSB +: 3];
                        ad_event = 1'b1; // [RULE_01]
                    end else begin
                        next_st.sar[st.bit_idx - 4'h1] = 1'b0; // [RULE_12]
                        next_st.bit_idx = st.bit_idx - 4'h1;
                        next_st.cnt     = trial_cycles(st.timing);
                    end
                end else begin
                    next_st.cnt = st.cnt - 8'h01;
                end
            end

            ST_THRESH: begin
                next_st.sample    = 1'b1;
                next_st.thr_prev  = comp_high;
                next_st.thr_valid = 1'b1;
                // the first look only primes thr_prev, so no edge is invented
                case (mode)
                    MODE_THRESH_HI: begin
                        crossed = st.thr_valid && !st.thr_prev && comp_high; // [RULE_02]
                    end
                    MODE_THRESH_LO: begin
                        crossed = st.thr_valid && st.thr_prev && !comp_high; // [RULE_02]
                    end
                    default: begin
                        crossed = 1'b0;
                    end
                endcase
                if (crossed) begin
                    ad_event      = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end

            default: begin
                next_st.state = ST_IDLE;
            end
        endcase

        // a command write overrides the sequencer state, threshold watch included
        if (wr_done && hit(paddr, IDX_COMMAND)) begin
            next_st.command = pwdata[7:0]; // [RULE_21] [RULE_23]
            // strobes drop at once so a cut window never leaks
            next_st.sample  = 1'b0;
            next_st.zero    = 1'b0;
            if (pwdata[CMD_GO_BIT]) begin
                next_st.state = ST_DELAY; // [RULE_24] [RULE_25] [RULE_06] [RULE_07]
                next_st.cnt   = 8'(SAMPLE_DELAY_CYC);
            end else begin
                next_st.state = ST_ARMED; // [RULE_24] [RULE_06]
            end
        end

        // hardware set beats a software clear in the same cycle
        if (ad_event) begin
            next_st.pending[IRQ_AD_BIT] = 1'b1; // [RULE_01] [RULE_17]
        end
        next_st.irq = next_st.pending[IRQ_AD_BIT] && next_st.mask[IRQ_AD_BIT]; // [RULE_16]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st         <= '0;

            // fields loaded with their named reset values, zero or not
            st.state   <= ST_IDLE;
            st.command <= RST_COMMAND;
            st.test    <= RST_TEST;
            st.timing  <= RST_TIMING;
            st.result  <= RST_RESULT;
            st.mask    <= RST_MASK;
            st.pending <= RST_PENDING;
        end else begin
            st <= next_st;
        end
    end

    // outputs are register fields, no logic after the flops
    assign prdata                 = st.rdata;
    assign pready                 = st.ready;
    assign pslverr                = st.err;

    assign approximation_register = st.sar; // [RULE_11]
    assign mux_channel            = st.command[CMD_CHAN_LSB +: 2]; // [RULE_20] [RULE_08]
    assign test_enable_bit        = st.test[TEST_TE_BIT]; // [RULE_05] [RULE_26]
    assign test_voltage_select    = st.test[TEST_TV_BIT]; // [RULE_26]
    assign zero_offset_adjust     = st.test[TEST_OFF_LSB +: 2]; // [RULE_05]

    assign sample_switch          = st.sample;
    assign comparator_zero        = st.zero;
    assign ad_irq                 = st.irq;

endmodule

// ==== tb/sar_analog_model.sv ====
`timescale 1ns/10ps
module sar_analog_model (
    input  wire logic [3:0][9:0] chan_level,
    input  wire logic [1:0]      mux_channel,
    input  wire logic            test_enable_bit,
    input  wire logic            test_voltage_select,
    input  wire logic [9:0]      approximation_register,
    output logic                 comp_high
);
    // ideal comparator, no settling; the reference beats every code and ground none
    always_comb begin
        if (test_enable_bit)
            comp_high = test_voltage_select;
        else
            comp_high = chan_level[mux_channel] > approximation_register;
    end
endmodule

// ==== tb/sar_adc_checker.sv ====
`timescale 1ns/10ps
module sar_adc_checker
    import sar_adc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [15:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [9:0]  approximation_register,
    input wire logic [1:0]  mux_channel,
    input wire logic        test_enable_bit,
    input wire logic        test_voltage_select,
    input wire logic [1:0]  zero_offset_adjust,
    input wire logic        sample_switch,
    input wire logic        comparator_zero,
    input wire logic        ad_irq
);
    logic       wr;
    logic       cmd_go;
    logic       mask_bit;
    logic [3:0] test_q;
    assign wr     = psel && penable && pready && pwrite;
    assign cmd_go = wr && paddr == 16'h7EB0 && pwdata[CMD_GO_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_bit <= 1'b0;
            test_q   <= 4'h0;
        end else begin
            if (wr && paddr == 16'h0020)
                mask_bit <= pwdata[IRQ_AD_BIT];
            if (wr && paddr == 16'h7EB8)
                test_q <= pwdata[3:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wait_state; psel && !penable |=> !pready ##1 pready; endproperty
    a_wait_state: assert property (p_wait_state) else $error("ready not after one wait state");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_irq_masked; ad_irq |-> mask_bit || $past(mask_bit); endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("request while masked");
    property p_delay_clear;
        cmd_go |=> ##1 (approximation_register == SAR_CLEAR && mux_channel == $past(pwdata[1:0], 2));
    endproperty
    a_delay_clear: assert property (p_delay_clear) else $error("delay without clear or channel");
    property p_start_window; cmd_go |=> !sample_switch ##[1:3] sample_switch; endproperty
    a_start_window: assert property (p_start_window) else $error("sample window late");
    property p_zero_after; comparator_zero |-> ($past(sample_switch) && !sample_switch) ##1 !comparator_zero; endproperty
    a_zero_after: assert property (p_zero_after) else $error("zeroing out of place");
    property p_half_scale; comparator_zero |=> ##[0:1] approximation_register[9:2] == SAR_HALF_SCALE[9:2]; endproperty
    a_half_scale: assert property (p_half_scale) else $error("first trial not half scale");
    property p_test_out;
        wr && paddr == 16'h7EB8 |=> ##1 {zero_offset_adjust, test_voltage_select, test_enable_bit} == test_q;
    endproperty
    a_test_out: assert property (p_test_out) else $error("test outputs not updated");
endmodule
bind sar_adc_sequencer sar_adc_checker sar_adc_checker_inst (.*);

// ==== tb/test_sar_adc_sequencer.sv ====
`timescale 1ns/10ps
module test_sar_adc_sequencer;
    import sar_adc_pkg::*;
    localparam logic [15:0] A_MASK = 16'h0020, A_PEND = 16'h0024, A_RES = 16'h7EA8, A_CMD = 16'h7EB0;
    localparam logic [15:0] A_TEST = 16'h7EB8, A_TIME = 16'h7EBC, A_PIN = 16'h7F68;
    logic            pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic            epa_event = 1'b0, irq_on = 1'b0;
    logic [15:0]     paddr = 16'h0000;
    logic [31:0]     pwdata = 32'h0, prdata, rd;
    logic            pready, pslverr, err, comp_high, test_enable_bit, test_voltage_select;
    logic            sample_switch, comparator_zero, ad_irq;
    logic [7:0]      port_zero_pins = 8'hA5;
    logic [9:0]      approximation_register;
    logic [1:0]      mux_channel, zero_offset_adjust;
    logic [3:0][9:0] chan_level = '0;
    int              error_cnt = 0, n_checks = 0, cyc = 0, t0, dur, d10;
    sar_adc_sequencer sar_adc_sequencer_inst (.*);
    sar_analog_model sar_analog_model_inst (.*);
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // master holds the whole request until pready is sampled high
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        // one idle edge between transfers, so psel is never driven twice at once
        @(posedge pclk);
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        psel   <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] e, input string nm);
        apb(a, 1'b0, 32'h0);
        chk(nm, rd, e);
    endtask
    // polls the result word, never the pin state, so accuracy is not disturbed
    task automatic conv(input logic [7:0] cmd, input logic [9:0] code);
        int n;
        n = 0;
        apb(A_CMD, 1'b1, {24'h0, cmd});
        if (!cmd[3]) begin
            repeat (20) @(posedge pclk);
            rdchk(A_PEND, 32'h0, "armed_wait");
            epa_event <= 1'b1;
            @(posedge pclk);
            epa_event <= 1'b0;
        end
        t0 = cyc;
        apb(A_RES, 1'b0, 32'h0);
        chk("busy", rd[3], 1'b1);
        while (rd[3] !== 1'b0 && n < 100) begin
            apb(A_RES, 1'b0, 32'h0);
            n++;
        end
        dur = cyc - t0;
        chk("result_hi", rd[15:8], code[9:2]);
        chk("result_low", rd[3:0], {1'b0, cmd[2:0]});
        if (!cmd[4]) chk("result_lsb", rd[7:6], code[1:0]);
        rdchk(A_PEND, 32'h2, "pending");
        chk("irq", ad_irq, irq_on);
        apb(A_PEND, 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq_clear", ad_irq, 1'b0);
    endtask
    task automatic watch(input logic [7:0] cmd, input logic [9:0] after_lvl);
        apb(A_CMD, 1'b1, {24'h0, cmd});
        repeat (40) @(posedge pclk);
        rdchk(A_PEND, 32'h0, "no_cross");
        chan_level[0] <= after_lvl;
        repeat (10) @(posedge pclk);
        rdchk(A_PEND, 32'h2, "crossed");
        apb(A_PEND, 1'b1, 32'h0);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(A_CMD, {24'h0, RST_COMMAND}, "cmd_reset");
        rdchk(A_TEST, {24'h0, RST_TEST}, "test_reset");
        rdchk(A_RES, {16'h0, RST_RESULT}, "result_reset");
        rdchk(A_TIME, 32'h0, "time_reset");
        rdchk(A_MASK, 32'h0, "mask_reset");
        rdchk(A_PEND, 32'h0, "pend_reset");
        apb(16'h0100, 1'b0, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        chk("unmapped", rd, 32'h0);
        apb(A_TIME, 1'b1, 32'h25);
        rdchk(A_TIME, 32'h25, "time_rw");
        port_zero_pins <= 8'h3C;
        rdchk(A_PIN, 32'h3C, "pins");
        apb(A_MASK, 1'b1, 32'h2);
        irq_on = 1'b1;
        chan_level[1] <= 10'h2A6;
        conv(8'h0D, 10'h2A6);
        d10 = dur;
        conv(8'h1D, 10'h2A6);
        chk("short_8bit", dur < d10, 1'b1);
        chan_level[3] <= 10'h3FF;
        conv(8'h0F, 10'h3FF);
        apb(A_TEST, 1'b1, 32'h03);
        conv(8'h0C, 10'h3FF);
        apb(A_TEST, 1'b1, 32'h0D);
        conv(8'h0C, 10'h000);
        apb(A_TEST, 1'b1, 32'h00);
        apb(A_MASK, 1'b1, 32'h0);
        irq_on = 1'b0;
        chan_level[2] <= 10'h155;
        conv(8'h06, 10'h155);
        apb(A_RES, 1'b1, 32'h8000);
        chan_level[0] <= 10'h100;
        watch(8'h2C, 10'h300);
        watch(8'h3C, 10'h100);
        apb(A_CMD, 1'b1, 32'h2C);
        repeat (40) @(posedge pclk);
        conv(8'h0C, 10'h100);
        print_verdict();
    end
endmodule
